// ===== hw/bfrc_map.vh
// constants for the burst flash read controller
`ifndef BFRC_MAP_VH
`define BFRC_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BFRC_CTRL_OFS      3'h0
`define BFRC_STAT_OFS      3'h4

// ----------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------
`define BFRC_CTRL_FAST_BIT 0
`define BFRC_CTRL_RESET    1'h0
`define BFRC_STAT_FAST_BIT 0
`define BFRC_STAT_ST_LO    4
`define BFRC_STAT_ST_HI    5
`define BFRC_STAT_CT_LO    8
`define BFRC_STAT_CT_HI    9
`define BFRC_STAT_N_LO     12
`define BFRC_STAT_N_HI     16

// ----------------------------------------------------------------
// cycle numbers within a transaction (n counts edges from start)
// ----------------------------------------------------------------
`define BFRC_N_START       5'h01
`define BFRC_N_MAX         5'h1F
`define BFRC_SLOW_ADV_ON   5'h03
`define BFRC_OE_ON         5'h04
`define BFRC_SLOW_RDY_ON   5'h06
`define BFRC_FAST_RDY_ON   5'h04
`define BFRC_WE_ON         5'h02
`define BFRC_WE_OFF        5'h03
`define BFRC_WR_RDY        5'h04

`endif

// ===== hw/bfrc_counter.v
// two-bit burst counter that feeds the flash low address lines
`timescale 1ns/1ps

module bfrc_counter #(
  parameter CW = 2
) (
  // clock and reset
  input  wire          clk,
  input  wire          arst_n,
  // control
  input  wire          load,
  input  wire [CW-1:0] load_value,
  input  wire          inc,
  // count out
  output reg  [CW-1:0] count
);

  // ----------------------------------------------------------------
  // modulo increment
  // ----------------------------------------------------------------
  // wraps at 2**CW so any start value walks a full burst
  function [CW-1:0] wrap_inc;
    input [CW-1:0] v;
    begin
      wrap_inc = v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // counter register
  // ----------------------------------------------------------------
  // load takes priority over a plain step
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {CW{1'b0}}; // RULE16
    end else if (load) begin
      count <= load_value;
    end else if (inc) begin
      count <= wrap_inc(count); // RULE17
    end
  end

endmodule

// ===== hw/bfrc_ctrl.v
// burst flash read controller: processor bus to synchronous flash
// Operation
// (RULE1) idle holds latch, address valid, direct path
// (RULE2) flash chip enable active while idle
// (RULE3) read start loads counter plus one
// (RULE4) slow mode: valid off, counter path at 1
// (RULE5) counter drives low address until end
// (RULE6) slow mode: valid on odd, off even cycles
// (RULE7) counter steps only while valid asserted; the code also steps it in a write on each non-last ready, with valid off
// (RULE8) output enable asserted from cycle 4
// (RULE9) slow mode: ready at 6, 8, 10, 12
// (RULE10) burst last with ready ends transaction
// (RULE11) fast mode: valid held, no stretching
// (RULE12) fast mode: ready at 4, 5, 6, 7
// (RULE13) write: counter and select before write enable
// (RULE14) fast select resets 0, set by software
// (RULE15) ready inserts wait states for transfers
// (RULE16) reset gives idle, slow mode, counter clear
// (RULE17) burst counter wraps modulo four
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bfrc_map.vh"

module bfrc_ctrl #(
  parameter CW = 2,
  parameter NW = 5
) (
  // clock and reset
  input  wire          clk,
  input  wire          arst_n,
  // avalon-mm slave
  input  wire [2:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  input  wire [3:0]    avs_byteenable,
  output reg  [31:0]   avs_readdata,
  output reg           avs_waitrequest,
  // processor bus, same clock
  input  wire          cpu_addr_strobe_n,
  input  wire          cpu_write,
  input  wire [CW-1:0] cpu_low_addr,
  input  wire          cpu_chip_select_n,
  input  wire          cpu_burst_last_n,
  output reg           cpu_ready_n,
  // address path control
  output reg           address_latch_open,
  output reg           address_path_select,
  output wire [CW-1:0] burst_counter,
  // flash control
  output reg           flash_addr_valid_n,
  output reg           flash_ce_n,
  output reg           flash_oe_n,
  output reg           flash_we_n
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0; // anticipating a flash access
  localparam ST_READ  = 2'h1; // burst read in progress
  localparam ST_WRITE = 2'h2; // write in progress

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [1:0]    state;         // current state
  reg  [1:0]    next_state;    // state after this edge
  reg  [NW-1:0] n;             // cycle number in transaction
  reg  [NW-1:0] next_n;        // cycle number after this edge
  reg           fast_sel;      // software fast select bit
  reg           fast_act;      // mode in force for this access
  reg           next_valid_n;  // next address valid strobe
  reg           next_oe_n;     // next output enable
  reg           next_we_n;     // next write enable
  reg           next_ready_n;  // next processor ready
  reg           next_latch;    // next latch open
  reg           next_path;     // next direct path select
  reg           cnt_load;      // counter load this edge
  reg  [CW-1:0] cnt_value;     // counter load value
  reg           cnt_inc;       // counter step this edge
  wire          start_rd;      // read begins at this edge
  wire          start_wr;      // write begins at this edge
  wire          beat_done;     // processor took a transfer
  wire          bus_req;       // avalon request present
  wire          bus_take;      // avalon request taken now
  reg  [31:0]   next_rdata;    // read data decode

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturating step of the cycle number
  function [NW-1:0] n_step;
    input [NW-1:0] v;
    begin
      if (v == `BFRC_N_MAX) begin
        n_step = v;
      end else begin
        n_step = v + {{(NW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // ready due in a read at cycle v
  function rd_ready_due;
    input          fast;
    input [NW-1:0] v;
    begin
      if (fast) begin
        rd_ready_due = (v >= `BFRC_FAST_RDY_ON); // RULE12
      end else begin
        rd_ready_due = (v >= `BFRC_SLOW_RDY_ON) && !v[0]; // RULE9
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // transaction detection
  // ----------------------------------------------------------------
  // strobe sampled with direction: 0 read, 1 write
  assign start_rd = (state == ST_IDLE) && !cpu_addr_strobe_n &&
                    !cpu_chip_select_n && !cpu_write; // RULE3
  assign start_wr = (state == ST_IDLE) && !cpu_addr_strobe_n &&
                    !cpu_chip_select_n && cpu_write;
  // a transfer completes on the edge that sees our ready low
  assign beat_done = !cpu_ready_n;

  // ----------------------------------------------------------------
  // next state and cycle number
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    next_n     = n;
    case (state)
      ST_IDLE: begin
        if (start_rd) begin
          next_state = ST_READ;
          next_n     = `BFRC_N_START;
        end else if (start_wr) begin
          next_state = ST_WRITE;
          next_n     = `BFRC_N_START;
        end else begin
          next_n     = {NW{1'b0}};
        end
      end
      ST_READ: begin
        if (beat_done && !cpu_burst_last_n) begin
          next_state = ST_IDLE; // RULE10
          next_n     = {NW{1'b0}};
        end else begin
          next_n     = n_step(n);
        end
      end
      ST_WRITE: begin
        if (beat_done && !cpu_burst_last_n) begin
          next_state = ST_IDLE; // RULE10
          next_n     = {NW{1'b0}};
        end else if (beat_done) begin
          next_n     = `BFRC_N_START; // next write beat
        end else begin
          next_n     = n_step(n);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_n     = {NW{1'b0}};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next output values, taken from next state and cycle
  // ----------------------------------------------------------------
  always @* begin
    next_valid_n = 1'b1;
    next_oe_n    = 1'b1;
    next_we_n    = 1'b1;
    next_ready_n = 1'b1;
    next_latch   = 1'b0;
    next_path    = 1'b0; // counter feeds flash low lines
    case (next_state)
      ST_IDLE: begin
        next_valid_n = 1'b0; // RULE1
        next_latch   = 1'b1; // RULE1
        next_path    = 1'b1; // RULE1
      end
      ST_READ: begin
        // path stays on the counter for the whole read
        next_path = 1'b0; // RULE4 RULE5
        if (fast_act) begin
          next_valid_n = 1'b0; // RULE11
        end else begin
          // off at 1, 2, 4, 6, 8; on at 3, 5, 7
          next_valid_n = !((next_n >= `BFRC_SLOW_ADV_ON) &&
                           next_n[0]); // RULE4 RULE6
        end
        next_oe_n    = !(next_n >= `BFRC_OE_ON); // RULE8
        next_ready_n = !rd_ready_due(fast_act, next_n); // RULE15
      end
      ST_WRITE: begin
        // counter settles one edge before the enable drops
        next_we_n    = !((next_n >= `BFRC_WE_ON) &&
                         (next_n <= `BFRC_WE_OFF)); // RULE13
        next_ready_n = !(next_n == `BFRC_WR_RDY); // RULE15
      end
      default: begin
        next_valid_n = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // burst counter control
  // ----------------------------------------------------------------
  always @* begin
    cnt_load  = 1'b0;
    cnt_value = cpu_low_addr;
    cnt_inc   = 1'b0;
    if (start_rd) begin
      // processor supplies the first address, so skip past it
      cnt_load  = 1'b1;
      cnt_value = cpu_low_addr + {{(CW-1){1'b0}}, 1'b1}; // RULE3
    end else if (start_wr) begin
      cnt_load  = 1'b1; // RULE13
    end else if (state == ST_READ) begin
      cnt_inc   = !flash_addr_valid_n; // RULE7
    end else if (state == ST_WRITE) begin
      cnt_inc   = beat_done && cpu_burst_last_n;
    end
  end

  // burst counter instance
  bfrc_counter #(
    .CW (CW)
  ) u_counter (
    .clk        (clk),
    .arst_n     (arst_n),
    .load       (cnt_load),
    .load_value (cnt_value),
    .inc        (cnt_inc),
    .count      (burst_counter)
  );

  // ----------------------------------------------------------------
  // state and control registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_IDLE; // RULE16
      n        <= {NW{1'b0}};
      fast_act <= `BFRC_CTRL_RESET; // RULE16
    end else begin
      state <= next_state;
      n     <= next_n;
      // mode only changes between transactions
      if (state == ST_IDLE && !start_rd && !start_wr) begin
        fast_act <= fast_sel; // RULE14
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_addr_valid_n  <= 1'b0; // RULE1
      address_latch_open  <= 1'b1; // RULE1
      address_path_select <= 1'b1; // RULE1
      flash_ce_n          <= 1'b0; // RULE2
      flash_oe_n          <= 1'b1; // RULE16
      flash_we_n          <= 1'b1;
      cpu_ready_n         <= 1'b1; // RULE16
    end else begin
      flash_addr_valid_n  <= next_valid_n;
      address_latch_open  <= next_latch;
      address_path_select <= next_path;
      flash_ce_n          <= 1'b0; // RULE2
      flash_oe_n          <= next_oe_n;
      flash_we_n          <= next_we_n;
      cpu_ready_n         <= next_ready_n;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state: waitrequest drops for one cycle per request
  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;

  // read data decode, unmapped reads as zero
  always @* begin
    next_rdata = 32'h00000000;
    case (avs_address)
      `BFRC_CTRL_OFS: begin
        next_rdata[`BFRC_CTRL_FAST_BIT] = fast_sel;
      end
      `BFRC_STAT_OFS: begin
        next_rdata[`BFRC_STAT_FAST_BIT] = fast_act;
        next_rdata[`BFRC_STAT_ST_HI:`BFRC_STAT_ST_LO] = state;
        next_rdata[`BFRC_STAT_CT_HI:`BFRC_STAT_CT_LO] = burst_counter;
        next_rdata[`BFRC_STAT_N_HI:`BFRC_STAT_N_LO]   = n;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // handshake, read data and control register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      fast_sel        <= `BFRC_CTRL_RESET; // RULE14
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= next_rdata;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (bus_take && avs_write && avs_byteenable[0] &&
          avs_address == `BFRC_CTRL_OFS) begin
        fast_sel <= avs_writedata[`BFRC_CTRL_FAST_BIT]; // RULE14
      end
    end
  end

endmodule

// ===== verification/bfrc_assertions.sv
// port checker for the burst flash read controller
`timescale 1ns/1ps

module bfrc_chk #(
  parameter CW = 2
) (
  // clock and reset
  input wire          clk,
  input wire          arst_n,
  // processor bus
  input wire          cpu_addr_strobe_n,
  input wire          cpu_write,
  input wire [CW-1:0] cpu_low_addr,
  input wire          cpu_chip_select_n,
  input wire          cpu_burst_last_n,
  input wire          cpu_ready_n,
  // address path and flash
  input wire          address_latch_open,
  input wire          address_path_select,
  input wire [CW-1:0] burst_counter,
  input wire          flash_addr_valid_n,
  input wire          flash_ce_n,
  input wire          flash_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // cycle number and mode seen at the pins
  // ----------------------------------------------------------------
  reg  [4:0] n;    // edges since read start
  reg        slow; // valid off at cycle 1 means stretching
  wire go = address_latch_open && !cpu_addr_strobe_n &&
            !cpu_chip_select_n && !cpu_write;
  wire rd = !address_latch_open;
  // count edges of a transfer, saturating
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n    <= 5'h00;
      slow <= 1'b1;
    end else begin
      if (address_latch_open)
        n <= 5'h01;
      else if (n != 5'h1F)
        n <= n + 5'h01;
      if (rd && n == 5'h01)
        slow <= flash_addr_valid_n;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_idle_direct: assert property (
    address_latch_open |-> address_path_select && !flash_addr_valid_n)
    else $error("idle path wrong");
  a_idle_chip_on: assert property (
    address_latch_open |-> !flash_ce_n)
    else $error("chip enable off in idle");
  a_start_load: assert property (
    go |=> rd && burst_counter == $past(cpu_low_addr) + 2'h1)
    else $error("counter not loaded plus one");
  a_path_counter: assert property (
    rd |-> !address_path_select)
    else $error("counter path not selected");
  a_count_step: assert property (
    rd && !flash_addr_valid_n |=> address_latch_open ||
      burst_counter == $past(burst_counter) + 2'h1)
    else $error("counter did not step");
  a_count_hold: assert property (
    rd && flash_addr_valid_n |=> address_latch_open || $stable(burst_counter))
    else $error("counter moved without valid");
  a_slow_valid: assert property (
    rd && slow && n >= 5'h02 |-> flash_addr_valid_n == !n[0])
    else $error("stretch pattern wrong");
  a_fast_valid: assert property (
    rd && !slow && n >= 5'h02 |-> !flash_addr_valid_n)
    else $error("valid dropped in fast mode");
  a_oe_cycle: assert property (
    rd |-> flash_oe_n == (n < 5'h04))
    else $error("output enable cycle wrong");
  a_slow_ready: assert property (
    rd && slow && n >= 5'h02 |-> cpu_ready_n == !(n >= 5'h06 && !n[0]))
    else $error("slow ready cycle wrong");
  a_fast_ready: assert property (
    rd && !slow && n >= 5'h02 |-> cpu_ready_n == (n < 5'h04))
    else $error("fast ready cycle wrong");
  a_last_ends: assert property (
    rd && !cpu_ready_n && !cpu_burst_last_n |=>
      address_latch_open && cpu_ready_n)
    else $error("burst last did not end read");
endmodule

bind bfrc_ctrl bfrc_chk #(.CW(CW)) u_chk (
  .clk, .arst_n, .cpu_addr_strobe_n, .cpu_write, .cpu_low_addr,
  .cpu_chip_select_n, .cpu_burst_last_n, .cpu_ready_n,
  .address_latch_open, .address_path_select, .burst_counter,
  .flash_addr_valid_n, .flash_ce_n, .flash_oe_n);

// ===== verification/bfrc_cpu_model.sv
// processor bus model issuing burst reads
`timescale 1ns/1ps

module bfrc_cpu_model (
  // clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // commands from the bench
  input  wire       go,
  input  wire       use_cs,
  input  wire [1:0] st_a,
  input  wire [2:0] words,
  // processor bus
  input  wire       cpu_ready_n,
  output reg        cpu_addr_strobe_n,
  output reg        cpu_write,
  output reg        cpu_chip_select_n,
  output reg        cpu_burst_last_n,
  output reg  [1:0] cpu_low_addr,
  output reg        busy
);
  reg [2:0] left; // words still owed
  // one-cycle strobe, then count ready pulses
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_addr_strobe_n <= 1'b1;
      cpu_write         <= 1'b0;
      cpu_chip_select_n <= 1'b1;
      cpu_burst_last_n  <= 1'b1;
      cpu_low_addr      <= 2'h0;
      busy              <= 1'b0;
      left              <= 3'h0;
    end else begin
      cpu_addr_strobe_n <= 1'b1;
      // address lines are not held once the strobe is gone
      cpu_low_addr <= ~cpu_low_addr;
      if (!busy && go) begin // start read, direction 0
        cpu_addr_strobe_n <= 1'b0;
        cpu_low_addr      <= st_a;
        cpu_chip_select_n <= !use_cs;
        cpu_burst_last_n  <= (words != 3'h1);
        left              <= words;
        busy              <= 1'b1;
      end else if (busy && (cpu_chip_select_n ||
                            (!cpu_ready_n && left == 3'h1))) begin
        busy              <= 1'b0;
        cpu_chip_select_n <= 1'b1;
        cpu_burst_last_n  <= 1'b1;
      end else if (busy && !cpu_ready_n) begin
        left <= left - 3'h1;
        if (left == 3'h2)
          cpu_burst_last_n <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/bfrc_tb.sv
// self-checking bench for the burst flash read controller
`timescale 1ns/1ps

module testbench;
  reg         clk = 1'b0;
  reg         arst_n;
  reg  [2:0]  avs_address;
  reg         avs_read, avs_write;
  reg  [31:0] avs_writedata;
  reg  [3:0]  avs_byteenable;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        cpu_addr_strobe_n, cpu_write, cpu_chip_select_n;
  wire        cpu_burst_last_n, cpu_ready_n, busy;
  wire [1:0]  cpu_low_addr, burst_counter;
  wire        address_latch_open, address_path_select;
  wire        flash_addr_valid_n, flash_ce_n, flash_oe_n, flash_we_n;
  reg         go, use_cs;
  reg  [1:0]  st_a;
  reg  [2:0]  words;
  int         error_cnt, samples_checked, cyc;
  int         rdy_q[$];
  logic [1:0] adr_q[$];
  // 100 ns clock
  always #50 clk = ~clk;
  bfrc_ctrl uut (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .cpu_addr_strobe_n, .cpu_write, .cpu_low_addr, .cpu_chip_select_n,
    .cpu_burst_last_n, .cpu_ready_n, .address_latch_open,
    .address_path_select, .burst_counter, .flash_addr_valid_n,
    .flash_ce_n, .flash_oe_n, .flash_we_n);
  bfrc_cpu_model u_cpu (.clk, .arst_n, .go, .use_cs, .st_a, .words,
    .cpu_ready_n, .cpu_addr_strobe_n, .cpu_write, .cpu_chip_select_n,
    .cpu_burst_last_n, .cpu_low_addr, .busy);
  // record ready cycles and flash addresses clocked in
  always @(posedge clk) begin
    cyc <= (address_latch_open && !cpu_addr_strobe_n &&
            !cpu_chip_select_n) ? 1 : cyc + 1;
    if (cpu_ready_n === 1'b0)
      rdy_q.push_back(cyc);
    if (flash_addr_valid_n === 1'b0 && address_latch_open === 1'b0)
      adr_q.push_back(burst_counter);
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task av(input bit wr, input [2:0] a, input [31:0] d, input [3:0] be,
          output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  // one processor burst, then ready cycles and addresses compared
  task burst(input bit fast, input [1:0] a, input int w, input bit cs);
    int i;
    rdy_q.delete();
    adr_q.delete();
    @(posedge clk);
    go <= 1'b1;
    st_a <= a;
    words <= w;
    use_cs <= cs;
    @(posedge clk);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (busy !== 1'b0 && i < 100);
    if (i >= 100) begin
      error_cnt++;
      tally_and_finish;
    end
    chk(rdy_q.size(), cs ? w : 0);
    for (i = 0; i < rdy_q.size(); i++)
      chk(rdy_q[i], fast ? 4 + i : 6 + 2 * i);
    for (i = 0; cs && i < w - 1; i++)
      chk(adr_q[i], (a + i + 1) % 4);
    chk({address_latch_open, address_path_select, flash_oe_n,
         flash_we_n}, 4'hF);
    $display("burst from %0d of %0d words done", a, w);
  endtask
  initial begin
    logic [31:0] q;
    error_cnt = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    {avs_address, avs_read, avs_write} = 5'h00;
    {avs_writedata, avs_byteenable} = 36'h0;
    {go, use_cs, st_a, words} = 7'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({address_latch_open, flash_addr_valid_n, address_path_select,
         flash_ce_n, flash_oe_n, cpu_ready_n, burst_counter}, 8'hAC);
    av(0, 3'h0, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    av(0, 3'h2, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    burst(0, 2'h2, 4, 1);
    burst(0, 2'h3, 1, 1);
    burst(0, 2'h1, 4, 0);
    av(1, 3'h0, 32'h1, 4'h0, q);
    av(0, 3'h0, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    av(1, 3'h0, 32'h1, 4'h1, q);
    av(0, 3'h0, 32'h0, 4'hF, q);
    chk(q, 32'h1);
    burst(1, 2'h3, 4, 1);
    burst(1, 2'h0, 2, 1);
    tally_and_finish;
  end
endmodule
